// *** aspbg_pkg.sv ***
/*
  shared constants for the serial port with baud generator:
  prescaler counts, frame bit counts, clock source codes, reset values.
  assumes: every design file names items as aspbg_pkg::name.
*/
package aspbg_pkg;
  // timer clock source codes on the clock select port
  localparam logic [2:0] CSEL_SYS     = 3'h0;  // system clock, undivided
  localparam logic [2:0] CSEL_DIV4    = 3'h1;  // system clock / 4
  localparam logic [2:0] CSEL_DIV12   = 3'h2;  // system clock / 12
  localparam logic [2:0] CSEL_DIV48   = 3'h3;  // system clock / 48
  localparam logic [2:0] CSEL_EXTOSC  = 3'h4;  // external oscillator / 8
  localparam logic [2:0] CSEL_EXTPIN  = 3'h5;  // external timer input pin
  // prescaler end counts
  localparam logic [3:0] DIV12_LAST   = 4'hB;  // mod-12 counter top
  localparam logic [1:0] DIV4_PHASE   = 2'h3;  // low bits at every 4th count
  localparam logic [1:0] DIV48_LAST   = 2'h3;  // fourth /12 tick
  localparam logic [2:0] OSC_DIV_LAST = 3'h7;  // eighth oscillator edge
  // baud timer
  localparam logic [7:0] TIMER_TOP    = 8'hFF; // overflow point
  localparam logic [7:0] TIMER_RST    = 8'h00; // counter value after reset
  // frame shapes: tx bits after the start bit, stop included; rx data samples only
  localparam logic [3:0] TX_LEFT_8    = 4'h9;  // 8 data + stop
  localparam logic [3:0] TX_LEFT_9    = 4'hA;  // 8 data + ninth + stop
  localparam logic [3:0] RX_DATA_8    = 4'h8;  // data samples, 8-bit frame
  localparam logic [3:0] RX_DATA_9    = 4'h9;  // data samples, 9-bit frame
  // receive buffer after reset
  localparam logic [7:0] RXBUF_RST    = 8'h00;
  // transmit fifo shape
  localparam int         FIFO_DEPTH   = 32;
  localparam int         FIFO_WIDTH   = 8;
endpackage

// *** aspbg_fifo_if.sv ***
/*
  carrier between the port logic and its transmit fifo.
  assumes: one filler, one drain, same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface aspbg_fifo_if #(parameter int W = 8);
  logic         push_valid;  // filler offers a word
  logic         push_ready;  // fifo has room
  logic [W-1:0] push_data;   // offered word
  logic         pop_valid;   // fifo holds a word
  logic         pop_ready;   // drain takes the word
  logic [W-1:0] pop_data;    // oldest word
  modport fill  (output push_valid, output push_data, input push_ready);
  modport store (input push_valid, input push_data, output push_ready,
                 output pop_valid, output pop_data, input pop_ready);
  modport drain (input pop_valid, input pop_data, output pop_ready);
endinterface
`default_nettype wire

// *** aspbg_fifo.sv ***
/*
  synchronous fifo with registered ready and valid flags.
  assumes: single clock, asynchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module aspbg_fifo #(
  parameter int W = aspbg_pkg::FIFO_WIDTH,
  parameter int D = aspbg_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // both sides
  aspbg_fifo_if.store f
);
  localparam int PW = $clog2(D);
  logic [W-1:0]  mem [D];      // word storage
  logic [PW-1:0] wr_ptr_r;     // next slot to write
  logic [PW-1:0] rd_ptr_r;     // oldest slot
  logic [PW:0]   cnt_r;        // words held
  logic [PW:0]   cnt_nxt;      // words held next cycle
  logic          do_push;      // accepted write
  logic          do_pop;       // accepted read

  assign do_push = f.push_valid && f.push_ready;
  assign do_pop  = f.pop_valid && f.pop_ready;
  assign f.pop_data = mem[rd_ptr_r];

  // occupancy next cycle
  always_comb begin
    cnt_nxt = cnt_r;
    if (do_push && !do_pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (do_pop && !do_push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // storage has no reset; only written slots are ever read
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_r] <= f.push_data;
    end
  end

  // pointers wrap because depth is a power of two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + PW'(do_push);
      rd_ptr_r <= rd_ptr_r + PW'(do_pop);
      cnt_r    <= cnt_nxt;
    end
  end

  // flags registered so the port pins come from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      f.push_ready <= 1'b1;
      f.pop_valid  <= 1'b0;
    end else begin
      f.push_ready <= (cnt_nxt != (PW+1)'(D));
      f.pop_valid  <= (cnt_nxt != '0);
    end
  end

  // an accepted write is counted when nothing leaves
  a_push_count: assert property (@(posedge clk) disable iff (rst)
    do_push && !do_pop |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("fifo write not counted");
  a_never_over: assert property (@(posedge clk) disable iff (rst)
    cnt_r == (PW+1)'(D) |-> !f.push_ready)
    else $error("fifo full but ready");
endmodule
`default_nettype wire

// *** aspbg_serial_port.sv ***
/*
  full-duplex asynchronous serial port with 8-bit auto-reload baud timer,
  hidden receive timer, buffered receive byte and a transmit fifo.
  assumes: control bits are plain ports held by the processor side;
  RXD, EXT_OSC and BAUD_TIMER_EXT_INPUT are asynchronous pins.
*/
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - full duplex, 8-bit and 9-bit frames only
// - received byte buffered apart from shifter
// - data-buffer writes load the transmitter
// - data-buffer reads give receive buffer only
// - interrupt on either done flag when enabled
// - done flags cleared only by software
// - tx bit clock from 8-bit reload timer
// - hidden rx timer copy, same reload byte
// - both timer overflows divided by two
// - start condition forces rx timer reload
// - six selectable timer clock sources
// - 8-bit frame ten bits, stop to ninth
// - transmit done set at stop bit start
// - load only if flag clear, multiproc check
// - 9-bit frame ninth bit both directions
module aspbg_serial_port (
  // clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       SYS_RST,
  // data buffer access
  input  wire logic       WR_STB,
  input  wire logic [7:0] WR_DATA,
  output logic            WR_READY,
  output logic [7:0]      RX_DATA,
  // frame control
  input  wire logic       FRAME_WIDTH_SELECT,
  input  wire logic       MULTIPROC_ENABLE,
  input  wire logic       RX_ENABLE,
  input  wire logic       TRANSMIT_NINTH_BIT,
  input  wire logic       PORT_INT_ENABLE,
  input  wire logic       TX_DONE_CLR,
  input  wire logic       RX_DONE_CLR,
  // baud timer control
  input  wire logic       TIMER_RUN,
  input  wire logic [2:0] CLK_SEL,
  input  wire logic [7:0] BAUD_RELOAD_BYTE,
  input  wire logic       EXT_OSC,
  input  wire logic       BAUD_TIMER_EXT_INPUT,
  // serial pins
  input  wire logic       RXD,
  output logic            TXD,
  // status
  output logic            TRANSMIT_DONE_FLAG,
  output logic            RECEIVE_DONE_FLAG,
  output logic            RECEIVED_NINTH_BIT,
  output logic [7:0]      BAUD_COUNTER_LOW,
  output logic            SERIAL_IRQ
);
  typedef enum logic {TX_IDLE, TX_SEND} aspbg_tx_e;
  typedef enum logic {RX_IDLE, RX_FRAME} aspbg_rx_e;

  aspbg_fifo_if #(.W(aspbg_pkg::FIFO_WIDTH)) txq ();

  logic [2:0] pin_meta_r;     // first sync stage, read only by second
  logic [2:0] pin_sync_r;     // {ext input, ext osc, rxd} synchronised
  logic [2:0] pin_prev_r;     // one more stage for edge detection
  logic [3:0] p12_r;          // mod-12 prescaler
  logic [1:0] p48_r;          // counts /12 ticks up to /48
  logic [2:0] osc8_r;         // external oscillator edge counter
  logic       tick;           // timer clock enable from chosen source
  logic [7:0] tx_tl_r;        // visible low counter
  logic [7:0] rx_tl_r;        // hidden receive copy
  logic       tx_half_r;      // tx overflow divide-by-two
  logic       rx_phase_r;     // rx overflow divide-by-two
  logic       tx_ovf;         // tx timer overflow
  logic       rx_ovf;         // rx timer overflow
  logic       tx_baud;        // one tx bit time elapsed
  logic       rx_sample;      // mid-bit sample point
  logic       start_det;      // falling edge on idle line
  aspbg_tx_e  tx_state_r;     // transmitter state
  logic [9:0] tx_shift_r;     // outgoing bits after start
  logic [3:0] tx_left_r;      // bits still to send
  logic       tx_take;        // pop a byte from fifo
  logic       tx_stop_evt;    // stop bit begins
  aspbg_rx_e  rx_state_r;     // receiver state
  logic [3:0] rx_cnt_r;       // samples taken in frame
  logic [8:0] rx_shift_r;     // incoming bits, newest on top
  logic [3:0] rx_ndata;       // data samples for this mode
  logic       rx_stop;        // stop sample point
  logic [7:0] rx_byte;        // byte assembled at stop
  logic       rx_ninth;       // ninth bit or stop bit
  logic       rx_load;        // buffer accepts the frame
  logic       tdone_r;        // transmit done flag
  logic       rdone_r;        // receive done flag
  logic [7:0] rx_buf_r;       // buffered receive register
  logic       ninth_r;        // received ninth bit
  logic       txd_r;          // line driver
  logic       irq_r;          // interrupt request

  // two-stage synchronisers for the three asynchronous pins
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          pin_meta_r[gi] <= 1'b1;
          pin_sync_r[gi] <= 1'b1;
          pin_prev_r[gi] <= 1'b1;
        end else begin
          pin_meta_r[gi] <= (gi == 0) ? RXD : (gi == 1) ? EXT_OSC : BAUD_TIMER_EXT_INPUT;
          pin_sync_r[gi] <= pin_meta_r[gi];
          pin_prev_r[gi] <= pin_sync_r[gi];
        end
      end
    end
  endgenerate

  // prescalers; /4 and /48 share the mod-12 counter to save flops
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      p12_r  <= '0;
      p48_r  <= '0;
      osc8_r <= '0;
    end else begin
      p12_r <= (p12_r == aspbg_pkg::DIV12_LAST) ? 4'h0 : p12_r + 4'h1;
      if (p12_r == aspbg_pkg::DIV12_LAST) begin
        p48_r <= p48_r + 2'h1;
      end
      if (pin_sync_r[1] && !pin_prev_r[1]) begin
        osc8_r <= osc8_r + 3'h1;
      end
    end
  end

  // timer clock source selection
  always_comb begin
    unique case (CLK_SEL)
      aspbg_pkg::CSEL_SYS:    tick = 1'b1;
      aspbg_pkg::CSEL_DIV4:   tick = (p12_r[1:0] == aspbg_pkg::DIV4_PHASE);
      aspbg_pkg::CSEL_DIV12:  tick = (p12_r == aspbg_pkg::DIV12_LAST);
      aspbg_pkg::CSEL_DIV48:  tick = (p12_r == aspbg_pkg::DIV12_LAST) &&
                                     (p48_r == aspbg_pkg::DIV48_LAST);
      aspbg_pkg::CSEL_EXTOSC: tick = pin_sync_r[1] && !pin_prev_r[1] &&
                                     (osc8_r == aspbg_pkg::OSC_DIV_LAST);
      aspbg_pkg::CSEL_EXTPIN: tick = !pin_sync_r[2] && pin_prev_r[2];
      default:                tick = 1'b0;  // unused codes stop the timer
    endcase
  end

  assign tx_ovf    = TIMER_RUN && tick && (tx_tl_r == aspbg_pkg::TIMER_TOP);
  assign rx_ovf    = TIMER_RUN && tick && (rx_tl_r == aspbg_pkg::TIMER_TOP);
  assign tx_baud   = tx_ovf && tx_half_r;
  assign rx_sample = rx_ovf && !rx_phase_r;
  assign start_det = (rx_state_r == RX_IDLE) && RX_ENABLE &&
                     !pin_sync_r[0] && pin_prev_r[0];

  // visible auto-reload timer, transmit bit clock
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_tl_r   <= aspbg_pkg::TIMER_RST;
      tx_half_r <= 1'b0;
    end else if (TIMER_RUN && tick) begin
      tx_tl_r <= tx_ovf ? BAUD_RELOAD_BYTE : tx_tl_r + 8'h01;
      if (tx_ovf) begin
        tx_half_r <= !tx_half_r;
      end
    end
  end

  // hidden copy; a start edge realigns it regardless of tx phase
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_tl_r    <= aspbg_pkg::TIMER_RST;
      rx_phase_r <= 1'b0;
    end else if (start_det) begin
      rx_tl_r    <= BAUD_RELOAD_BYTE;
      rx_phase_r <= 1'b0;
    end else if (TIMER_RUN && tick) begin
      rx_tl_r <= rx_ovf ? BAUD_RELOAD_BYTE : rx_tl_r + 8'h01;
      if (rx_ovf) begin
        rx_phase_r <= !rx_phase_r;
      end
    end
  end

  // every write goes to the transmit side; a write while fifo ready is low is dropped
  assign txq.push_valid = WR_STB;
  assign txq.push_data  = WR_DATA;
  assign txq.pop_ready  = tx_take;
  assign tx_take     = (tx_state_r == TX_IDLE) && tx_baud && txq.pop_valid;
  assign tx_stop_evt = (tx_state_r == TX_SEND) && tx_baud && (tx_left_r == 4'h1);

  aspbg_fifo #(.W(aspbg_pkg::FIFO_WIDTH), .D(aspbg_pkg::FIFO_DEPTH)) u_txq (
    .clk (REF_CLK),
    .rst (SYS_RST),
    .f   (txq.store)
  );

  // transmitter: start, data lsb first, optional ninth, stop
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_state_r <= TX_IDLE;
      tx_shift_r <= '1;
      tx_left_r  <= '0;
      txd_r      <= 1'b1;
    end else if (tx_take) begin
      tx_state_r <= TX_SEND;
      txd_r      <= 1'b0;
      tx_shift_r <= {1'b1, FRAME_WIDTH_SELECT ? TRANSMIT_NINTH_BIT : 1'b1,
                     txq.pop_data};
      tx_left_r  <= FRAME_WIDTH_SELECT ? aspbg_pkg::TX_LEFT_9 : aspbg_pkg::TX_LEFT_8;
    end else if ((tx_state_r == TX_SEND) && tx_baud) begin
      if (tx_left_r == 4'h0) begin
        tx_state_r <= TX_IDLE;  // stop bit time is over
      end else begin
        txd_r      <= tx_shift_r[0];
        tx_shift_r <= {1'b1, tx_shift_r[9:1]};
        tx_left_r  <= tx_left_r - 4'h1;
      end
    end
  end

  assign rx_ndata = FRAME_WIDTH_SELECT ? aspbg_pkg::RX_DATA_9 : aspbg_pkg::RX_DATA_8;
  assign rx_stop  = (rx_state_r == RX_FRAME) && rx_sample &&
                    (rx_cnt_r == rx_ndata + 4'h1);
  // 8-bit frame: stop bit becomes the ninth; 9-bit frame ignores the stop
  assign rx_byte  = FRAME_WIDTH_SELECT ? rx_shift_r[7:0] : rx_shift_r[8:1];
  assign rx_ninth = FRAME_WIDTH_SELECT ? rx_shift_r[8] : pin_sync_r[0];
  assign rx_load  = rx_stop && !rdone_r && (!MULTIPROC_ENABLE || rx_ninth);

  // receiver: samples mid-bit, first sample checks the start bit
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_state_r <= RX_IDLE;
      rx_cnt_r   <= '0;
      rx_shift_r <= '0;
    end else if (start_det) begin
      rx_state_r <= RX_FRAME;
      rx_cnt_r   <= '0;
    end else if ((rx_state_r == RX_FRAME) && rx_sample) begin
      if (rx_cnt_r == 4'h0 && pin_sync_r[0]) begin
        rx_state_r <= RX_IDLE;  // glitch, not a real start bit
      end else if (rx_stop) begin
        rx_state_r <= RX_IDLE;
      end else begin
        rx_cnt_r <= rx_cnt_r + 4'h1;
        if (rx_cnt_r != 4'h0) begin
          rx_shift_r <= {pin_sync_r[0], rx_shift_r[8:1]};
        end
      end
    end
  end

  // buffer is separate from the shifter, so a new frame can shift in
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_buf_r <= aspbg_pkg::RXBUF_RST;
      ninth_r  <= 1'b0;
    end else if (rx_load) begin
      rx_buf_r <= rx_byte;
      ninth_r  <= rx_ninth;
    end
  end

  // done flags: hardware sets, software clears, set wins a tie
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tdone_r <= 1'b0;
      rdone_r <= 1'b0;
    end else begin
      tdone_r <= tx_stop_evt || (tdone_r && !TX_DONE_CLR);
      rdone_r <= rx_load || (rdone_r && !RX_DONE_CLR);
    end
  end

  // interrupt request follows the flags one cycle later
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= PORT_INT_ENABLE && (tdone_r || rdone_r);
    end
  end

  assign WR_READY           = txq.push_ready;
  assign RX_DATA            = rx_buf_r;
  assign TXD                = txd_r;
  assign TRANSMIT_DONE_FLAG = tdone_r;
  assign RECEIVE_DONE_FLAG  = rdone_r;
  assign RECEIVED_NINTH_BIT = ninth_r;
  assign BAUD_COUNTER_LOW   = tx_tl_r;
  assign SERIAL_IRQ         = irq_r;

  a_tdone_set_wins: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    tx_stop_evt |=> tdone_r && txd_r) else $error("stop start lost flag");
  a_rdone_held: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    rdone_r && !RX_DONE_CLR |=> rdone_r) else $error("receive flag cleared by hardware");
  a_irq_follow: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    PORT_INT_ENABLE && (tdone_r || rdone_r) |=> irq_r) else $error("interrupt missing");
  a_no_overrun: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    rdone_r && !rx_load |=> $stable(rx_buf_r)) else $error("buffer overwritten");
  a_start_reload: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    start_det |=> rx_tl_r == $past(BAUD_RELOAD_BYTE) && !rx_phase_r)
    else $error("rx timer not realigned");
  a_baud_halving: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    tx_baud |-> tx_ovf && tx_half_r ##1 !tx_half_r)
    else $error("tx baud not halved");
  a_idle_line_high: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    tx_state_r == TX_IDLE && !$past(tx_take) |-> txd_r) else $error("idle line low");
  a_mpe_filter: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    rx_stop && MULTIPROC_ENABLE && !rx_ninth |=> $stable(rdone_r) || !rdone_r)
    else $error("multiproc filter failed");
endmodule
`default_nettype wire

// *** aspbg_remote_uart.sv ***
/*
  far-side serial transceiver model: sends frames on the port's receive
  line and captures frames from its transmit line.
  assumes: bit time is a whole number of reference clock cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module aspbg_remote_uart #(
  parameter int BIT_CYC = 32  // cycles per bit
) (
  // clock
  input  wire logic clk,
  // serial lines
  input  wire logic txd,
  output logic      rxd
);
  // idle high: the port needs a high line when reset lets go
  initial rxd = 1'b1;

  // one frame out, lsb first; b9 is the stop bit in 8-bit frames
  task automatic send_frame(input logic nine, input logic [7:0] d, input logic b9);
    logic [10:0] f;
    f = {1'b1, b9, d, 1'b0};
    @(posedge clk);
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      rxd <= f[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    // back to idle, one idle bit so the next start edge is clean
    rxd <= 1'b1;
    repeat (BIT_CYC) @(posedge clk);
  endtask

  // one frame in: bits[8] ninth or stop, bits[9] stop of 9-bit frames
  task automatic get_frame(input logic nine, input int limit,
                           output logic [9:0] bits, output logic ok);
    int n;
    bits = '0;
    ok   = 1'b0;
    n    = 0;
    do begin
      @(posedge clk);
      n++;
    end while (txd !== 1'b0 && n < limit);
    if (txd !== 1'b0)
      return;
    // sample every bit at its centre
    repeat (BIT_CYC / 2) @(posedge clk);
    ok = (txd === 1'b0);
    for (int i = 0; i < (nine ? 10 : 9); i++) begin
      repeat (BIT_CYC) @(posedge clk);
      bits[i] = txd;
    end
  endtask
endmodule
`default_nettype wire

// *** async_serial_port_baud_gen_tb.sv ***
/*
  self-checking bench for the serial port: reset state, clock sources,
  transmit frames, fifo fill and drain, receive filtering, full duplex.
  assumes: the remote model owns the receive line; reload 8'hF0.
*/
`timescale 1ns/100ps
`default_nettype none
module async_serial_port_baud_gen_tb;
  localparam logic [7:0] RELOAD  = 8'hF0;                   // overflow at twice baud
  localparam int         BIT_CYC = 2 * (256 - int'(RELOAD)); // two overflows a bit
  logic       ref_clk, sys_rst, wr_stb, wr_ready, frame_sel, mp_en, rx_en;
  logic       tb9, int_en, tx_clr, rx_clr, run, ext_osc, ext_pin, rxd, txd;
  logic       tx_done, rx_done, rx9, irq;
  logic [7:0] wr_data, rx_data, cnt_low;
  logic [7:0] cyc = 8'h00;  // free-running phase for the pin clocks
  logic [2:0] clk_sel;
  int         n_mismatch   = 0;
  int         total_checks = 0;

  aspbg_serial_port aspbg_serial_port_inst (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .WR_STB(wr_stb), .WR_DATA(wr_data),
    .WR_READY(wr_ready), .RX_DATA(rx_data), .FRAME_WIDTH_SELECT(frame_sel),
    .MULTIPROC_ENABLE(mp_en), .RX_ENABLE(rx_en), .TRANSMIT_NINTH_BIT(tb9),
    .PORT_INT_ENABLE(int_en), .TX_DONE_CLR(tx_clr), .RX_DONE_CLR(rx_clr), .TIMER_RUN(run),
    .CLK_SEL(clk_sel), .BAUD_RELOAD_BYTE(RELOAD), .EXT_OSC(ext_osc),
    .BAUD_TIMER_EXT_INPUT(ext_pin), .RXD(rxd), .TXD(txd), .TRANSMIT_DONE_FLAG(tx_done),
    .RECEIVE_DONE_FLAG(rx_done), .RECEIVED_NINTH_BIT(rx9), .BAUD_COUNTER_LOW(cnt_low),
    .SERIAL_IRQ(irq));

  aspbg_remote_uart #(.BIT_CYC(BIT_CYC)) aspbg_remote_uart_inst (
    .clk(ref_clk), .txd(txd), .rxd(rxd));

  // reference clock, 5 ns
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // pin clocks locked to the reference so periods come out exact
  always @(posedge ref_clk) begin
    cyc     <= cyc + 8'h01;
    ext_osc <= cyc[1];  // 4-cycle period
    ext_pin <= cyc[3];  // 16-cycle period
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %0h want %0h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic give_up();
    n_mismatch++;
    $display("[FAIL] %0t wait ran out", $time);
    complete_run();
  endtask

  task automatic clear_flags(input logic t, input logic r);
    @(posedge ref_clk);
    tx_clr <= t;
    rx_clr <= r;
    @(posedge ref_clk);
    tx_clr <= 1'b0;
    rx_clr <= 1'b0;
    @(posedge ref_clk);
  endtask

  // cycles between two reloads; sampled at the falling edge, settled
  task automatic ovf_wait(output int c);
    logic [7:0] prev;
    c = 0;
    do begin
      prev = cnt_low;
      @(negedge ref_clk);
      c++;
    end while (!(prev === 8'hFF && cnt_low === RELOAD) && c < 4000);
    if (c >= 4000)
      give_up();
  endtask

  task automatic clock_sources();
    // 16 ticks an overflow times each source's divide, source 0 in the low word
    logic [95:0] want = {16'h0100, 16'h0200, 16'h0300, 16'h00C0, 16'h0040, 16'h0010};
    logic [7:0]  held;
    int          c;
    for (int s = 0; s < 6; s++) begin
      @(posedge ref_clk);
      clk_sel <= 3'(s);
      ovf_wait(c);
      ovf_wait(c);
      check(16'(c), want[16*s +: 16], "overflow period");
    end
    // an unused select code must hold the counter still
    @(posedge ref_clk);
    clk_sel <= 3'h6;
    repeat (3) @(posedge ref_clk);
    held = cnt_low;
    repeat (100) @(posedge ref_clk);
    check(16'(cnt_low), 16'(held), "stopped counter");
    clk_sel <= aspbg_pkg::CSEL_SYS;
  endtask

  task automatic tx_single(input logic nine, input logic b9, input logic [7:0] d);
    logic [9:0] bits;
    logic       ok;
    int         c;
    c = 0;
    @(posedge ref_clk);
    frame_sel <= nine;
    tb9       <= b9;
    int_en    <= 1'b1;
    wr_stb    <= 1'b1;
    wr_data   <= d;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    fork
      aspbg_remote_uart_inst.get_frame(nine, 2000, bits, ok);
      begin
        do begin
          @(posedge ref_clk);
          c++;
        end while (txd !== 1'b0 && c < 2000);
        c = 0;
        do begin
          @(posedge ref_clk);
          c++;
        end while (tx_done !== 1'b1 && c < 2000);
        if (c >= 2000)
          give_up();
        check(16'(txd), 16'h1, "stop at done");
        check(16'(c == BIT_CYC * (nine ? 10 : 9) || c == BIT_CYC * (nine ? 10 : 9) + 1),
              16'h1, "done timing");
      end
    join
    check(16'({ok, bits}), 16'({1'b1, nine ? {1'b1, b9, d} : {2'b01, d}}), "tx frame");
    repeat (50) @(posedge ref_clk);
    check(16'({tx_done, irq}), 16'h3, "done held");
    clear_flags(1'b1, 1'b0);
    check(16'(tx_done), 16'h0, "done cleared");
  endtask

  task automatic fill_drain();
    logic [9:0] bits;
    logic       ok;
    @(posedge ref_clk);
    run       <= 1'b0;  // stalled timer: nothing drains while filling
    frame_sel <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      @(posedge ref_clk);
      wr_stb  <= 1'b1;
      wr_data <= 8'(i * 37 + 5);
    end
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check(16'(wr_ready), 16'h0, "fifo full");
    wr_stb  <= 1'b1;
    wr_data <= 8'hEE;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    run    <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      aspbg_remote_uart_inst.get_frame(1'b0, 2000, bits, ok);
      check(16'({ok, bits[8:0]}), 16'({2'b11, 8'(i * 37 + 5)}), "drained byte");
    end
    aspbg_remote_uart_inst.get_frame(1'b0, 1000, bits, ok);
    check(16'({ok, wr_ready}), 16'h1, "refused byte or not empty");
    clear_flags(1'b1, 1'b1);
  endtask

  task automatic rx_one(input logic nine, input logic [7:0] d, input logic b9, input logic mp,
                        input logic exp_ri, input logic [7:0] exp_d, input logic exp_9);
    @(posedge ref_clk);
    frame_sel <= nine;
    mp_en     <= mp;
    aspbg_remote_uart_inst.send_frame(nine, d, b9);
    check(16'(rx_done), 16'(exp_ri), "receive done");
    check(16'({rx_data, rx9}), 16'({exp_d, exp_9}), "receive byte");
  endtask

  task automatic rx_filter();
    @(posedge ref_clk);
    int_en <= 1'b0;
    rx_one(1'b0, 8'h3C, 1'b1, 1'b0, 1'b1, 8'h3C, 1'b1);
    check(16'(irq), 16'h0, "masked irq");
    int_en <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check(16'(irq), 16'h1, "receive irq");
    int_en <= 1'b0;
    rx_one(1'b0, 8'hC3, 1'b1, 1'b0, 1'b1, 8'h3C, 1'b1);
    clear_flags(1'b0, 1'b1);
    rx_one(1'b0, 8'h55, 1'b0, 1'b1, 1'b0, 8'h3C, 1'b1);
    rx_one(1'b1, 8'hA6, 1'b0, 1'b1, 1'b0, 8'h3C, 1'b1);
    rx_one(1'b1, 8'h6A, 1'b1, 1'b1, 1'b1, 8'h6A, 1'b1);
    clear_flags(1'b0, 1'b1);
    rx_one(1'b1, 8'h81, 1'b0, 1'b0, 1'b1, 8'h81, 1'b0);
    clear_flags(1'b0, 1'b1);
    // receive disabled: no start is taken, buffer and flag stay
    rx_en <= 1'b0;
    rx_one(1'b0, 8'hF7, 1'b1, 1'b0, 1'b0, 8'h81, 1'b0);
    rx_en <= 1'b1;
  endtask

  initial begin
    sys_rst = 1'b1;
    wr_data = 8'h00;
    clk_sel = aspbg_pkg::CSEL_SYS;
    rx_en   = 1'b1;
    {wr_stb, frame_sel, mp_en, tb9, int_en, tx_clr, rx_clr, run} = 8'h00;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    check(16'({txd, wr_ready, tx_done, rx_done, irq, rx9}), 16'h0030, "reset flags");
    check(16'({rx_data, cnt_low}), 16'({aspbg_pkg::RXBUF_RST, aspbg_pkg::TIMER_RST}),
          "reset bytes");
    run <= 1'b1;
    clock_sources();
    tx_single(1'b0, 1'b0, 8'hA5);
    tx_single(1'b1, 1'b0, 8'h5A);
    tx_single(1'b1, 1'b1, 8'h0F);
    fill_drain();
    rx_filter();
    // full duplex: a frame each way at once, rx started a little later
    fork
      tx_single(1'b0, 1'b0, 8'h96);
      begin
        repeat (5) @(posedge ref_clk);
        rx_one(1'b0, 8'h69, 1'b1, 1'b0, 1'b1, 8'h69, 1'b1);
      end
    join
    complete_run();
  end
endmodule
`default_nettype wire
